// ===== src/iob_pkg.sv
package iob_pkg;

  localparam int DATA_W   = 36;
  localparam int SEL_W    = 7;
  localparam int PHYS_W   = 4;
  localparam int CHAN_W   = 3;
  localparam int CNT_W    = 8;
  localparam int CHAN_LSB = 0;
  localparam int PHYS_LSB = 3;

  localparam int CLK_MHZ = 25;

  // Least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int SETTLE_NS   = 200;
  localparam int POLL_NS     = 400;
  localparam int VEC_NS      = 200;
  localparam int HOLD_NS     = 150;
  localparam int ACK_WAIT_NS = 2000;

  localparam logic [CNT_W-1:0] SETTLE_CYC   = CNT_W'(ns_to_cyc(SETTLE_NS));
  localparam logic [CNT_W-1:0] POLL_CYC     = CNT_W'(ns_to_cyc(POLL_NS));
  localparam logic [CNT_W-1:0] VEC_CYC      = CNT_W'(ns_to_cyc(VEC_NS));
  localparam logic [CNT_W-1:0] HOLD_CYC     = CNT_W'(ns_to_cyc(HOLD_NS));
  localparam logic [CNT_W-1:0] ACK_WAIT_CYC = CNT_W'(ns_to_cyc(ACK_WAIT_NS));
  localparam logic [CNT_W-1:0] CNT_ONE      = 8'h01;

  localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
  localparam logic [SEL_W-1:0]  SEL_RST  = 7'h00;

  typedef enum logic [2:0] {
    FN_CTL_OUT  = 3'b000,
    FN_CTL_IN   = 3'b001,
    FN_DATA_OUT = 3'b010,
    FN_DATA_IN  = 3'b011,
    FN_POLL     = 3'b100,
    FN_VEC      = 3'b101
  } iob_func_e;

endpackage : iob_pkg

// ===== src/iob_bus_if.sv
`timescale 1ns/1ps
interface iob_bus_if;
  logic [iob_pkg::SEL_W-1:0]  select_lines;
  logic [2:0]                 function_code;
  logic                       request_strobe;
  logic [iob_pkg::DATA_W-1:0] m_data_o;
  logic                       m_data_oe_n;
  logic [iob_pkg::DATA_W-1:0] c_data_o;
  logic                       c_data_oe_n;
  logic                       c_ack_o;
  logic                       c_ack_oe_n;
  logic                       c_transfer_ready_o;
  logic                       c_transfer_ready_oe_n;
  logic [iob_pkg::DATA_W-1:0] data_lines;
  logic                       acknowledge;
  logic                       transfer_ready;

  // Wired-OR resolution; released drivers contribute zero
  assign data_lines     = (m_data_oe_n ? '0 : m_data_o) | (c_data_oe_n ? '0 : c_data_o);
  assign acknowledge    = ~c_ack_oe_n & c_ack_o;
  assign transfer_ready = ~c_transfer_ready_oe_n & c_transfer_ready_o;

  modport master (
    output select_lines, function_code, request_strobe, m_data_o, m_data_oe_n,
    input  data_lines, acknowledge, transfer_ready
  );
  modport ctrl (
    input  select_lines, function_code, request_strobe, data_lines,
    output c_data_o, c_data_oe_n, c_ack_o, c_ack_oe_n, c_transfer_ready_o, c_transfer_ready_oe_n
  );
endinterface : iob_bus_if

// ===== src/iob_ctrl.sv
`timescale 1ns/1ps
module iob_ctrl (
  input  wire logic                               clk_sys,
  input  wire logic                               rst,
  iob_bus_if.ctrl                                 bus,
  input  wire logic [iob_pkg::SEL_W-1:0]          dev_code,
  input  wire logic [iob_pkg::PHYS_W-1:0]         phys_num,
  input  wire logic                               irq_req,
  input  wire logic [iob_pkg::CHAN_W-1:0]         irq_chan,
  input  wire logic                               ctl_ready,
  input  wire logic [iob_pkg::DATA_W-1:0]         rd_data,
  input  wire logic [iob_pkg::DATA_W-1:0]         vector_word,
  output logic                                    wr_valid,
  output logic [2:0]                              wr_func,
  output logic [iob_pkg::DATA_W-1:0]              wr_data,
  output logic                                    vec_taken
);

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_ACT  = 2'b01,
    C_TRANSFER_READY = 2'b10,
    C_POLL = 2'b11
  } iob_c_state_e;

  typedef struct packed {
    iob_c_state_e                st;
    logic [2:0]                  fn;
    logic [iob_pkg::DATA_W-1:0]  dout;
    logic                        dout_oe_n;
    logic                        ack_oe_n;
    logic                        transfer_ready_oe_n;
    logic                        wr_valid;
    logic [2:0]                  wr_func;
    logic [iob_pkg::DATA_W-1:0]  wr_data;
    logic                        vec_taken;
  } iob_c_s;

  iob_c_s q;
  iob_c_s d;

  logic chan_hit;
  logic phys_hit;
  logic dev_hit;

  assign chan_hit = irq_req && (bus.select_lines[iob_pkg::CHAN_LSB +: iob_pkg::CHAN_W] == irq_chan);
  assign phys_hit = bus.select_lines[iob_pkg::PHYS_LSB +: iob_pkg::PHYS_W] == phys_num;
  assign dev_hit  = bus.select_lines == dev_code;

  always_comb begin
    d           = q;
    d.wr_valid  = 1'b0;
    d.vec_taken = 1'b0;
    unique case (q.st)
      C_IDLE: begin
        // Unaddressed: all drivers stay released
        if (bus.request_strobe) begin
          d.fn = bus.function_code;
          if (bus.function_code == iob_pkg::FN_POLL) begin
            if (chan_hit) begin
              d.dout      = iob_pkg::DATA_W'(36'h1 << phys_num);
              d.dout_oe_n = 1'b0;
              d.st        = C_POLL;
            end
          end else if (bus.function_code == iob_pkg::FN_VEC) begin
            if (chan_hit && phys_hit) begin
              d.ack_oe_n = 1'b0;
              d.st       = C_ACT;
            end
          end else if (!bus.function_code[2] && dev_hit) begin
            d.ack_oe_n = 1'b0;
            d.st       = C_ACT;
          end
        end
      end
      C_ACT: begin
        if (!bus.request_strobe) begin
          d.ack_oe_n = 1'b1;
          d.st       = C_IDLE;
        end else if (ctl_ready) begin
          d.transfer_ready_oe_n = 1'b0;
          d.st        = C_TRANSFER_READY;
          if (q.fn == iob_pkg::FN_VEC) begin
            d.dout      = vector_word;
            d.dout_oe_n = 1'b0;
            d.vec_taken = 1'b1;
          end else if (q.fn[0]) begin
            d.dout      = rd_data;
            d.dout_oe_n = 1'b0;
          end else begin
            d.wr_valid = 1'b1;
            d.wr_func  = q.fn;
            d.wr_data  = bus.data_lines;
          end
        end
      end
      C_TRANSFER_READY: begin
        if (!bus.request_strobe) begin
          d.ack_oe_n  = 1'b1;
          d.transfer_ready_oe_n = 1'b1;
          d.dout_oe_n = 1'b1;
          d.st        = C_IDLE;
        end
      end
      C_POLL: begin
        // No acknowledge during poll; drop bit when strobe ends
        if (!bus.request_strobe) begin
          d.dout_oe_n = 1'b1;
          d.st        = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '{st: C_IDLE, fn: 3'h0, dout: iob_pkg::DATA_RST, dout_oe_n: 1'b1, ack_oe_n: 1'b1,
             transfer_ready_oe_n: 1'b1, wr_valid: 1'b0, wr_func: 3'h0, wr_data: iob_pkg::DATA_RST, vec_taken: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign bus.c_data_o    = q.dout;
  assign bus.c_data_oe_n = q.dout_oe_n;
  assign bus.c_ack_o     = 1'b1;
  assign bus.c_ack_oe_n  = q.ack_oe_n;
  assign bus.c_transfer_ready_o    = 1'b1;
  assign bus.c_transfer_ready_oe_n = q.transfer_ready_oe_n;
  assign wr_valid        = q.wr_valid;
  assign wr_func         = q.wr_func;
  assign wr_data         = q.wr_data;
  assign vec_taken       = q.vec_taken;

endmodule : iob_ctrl

// ===== src/iob_master.sv
`timescale 1ns/1ps
// What this block does
// - Execution unit or interrupt logic masters bus
// - One 36-bit two-way data path
// - Controller answers only its wired select code
// - Master drives full seven-bit device code
// - Controllers carry slot-based physical numbers
// - Function codes 000..011 select transfer kind
// - Addressed controller acknowledges, transfers data
// - No acknowledge in time: bridge handles
// - Transfer asserted only when controller ready
// - Interrupt channel on low three select lines
// - Chosen physical number on upper select lines
// - Poll: interrupting controllers show their number
// - Vector fetch selects one matching controller
// - Vector fetch: acknowledge, then word together with transfer
// - Transfer ends strobe; strobe end clears handshake
// - Poll: wait 400 ns, sample, drop strobe
// - Vector fetch: 200 ns settle before strobe
module iob_master (
  input  wire logic                               clk_sys,
  input  wire logic                               rst,
  iob_bus_if.master                               bus,
  input  wire logic                               io_req,
  input  wire logic [1:0]                         io_func,
  input  wire logic [iob_pkg::SEL_W-1:0]          io_select,
  input  wire logic [iob_pkg::DATA_W-1:0]         io_wdata,
  input  wire logic                               pi_req,
  input  wire logic [iob_pkg::CHAN_W-1:0]         pi_chan,
  output logic                                    busy,
  output logic                                    rsp_valid,
  output logic                                    rsp_pi,
  output logic                                    rsp_noack,
  output logic [iob_pkg::PHYS_W-1:0]              rsp_phys,
  output logic [iob_pkg::DATA_W-1:0]              rsp_data
);

  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_SETUP = 2'b01,
    M_WAIT  = 2'b10,
    M_HOLD  = 2'b11
  } iob_m_state_e;

  typedef struct packed {
    iob_m_state_e                st;
    logic [iob_pkg::CNT_W-1:0]   cnt;
    logic [iob_pkg::SEL_W-1:0]   sel;
    logic [2:0]                  fn;
    logic                        strobe;
    logic [iob_pkg::DATA_W-1:0]  dout;
    logic                        dout_oe_n;
    logic                        poll;
    logic                        busy;
    logic                        rsp_valid;
    logic                        rsp_pi;
    logic                        rsp_noack;
    logic [iob_pkg::PHYS_W-1:0]  rsp_phys;
    logic [iob_pkg::DATA_W-1:0]  rsp_data;
  } iob_m_s;

  iob_m_s q;
  iob_m_s d;

  // Lowest physical number wins when several controllers interrupt
  function automatic logic [iob_pkg::PHYS_W:0] pick_lowest(
    input logic [(1 << iob_pkg::PHYS_W)-1:0] bits
  );
    logic [iob_pkg::PHYS_W:0] r;
    r = '0;
    for (int i = (1 << iob_pkg::PHYS_W) - 1; i >= 0; i--) begin
      if (bits[i]) begin
        r = {1'b1, iob_pkg::PHYS_W'(i)};
      end
    end
    return r;
  endfunction : pick_lowest

  // Down-counters expire on their last cycle; a zero load still waits one
  function automatic logic cnt_expired(
    input logic [iob_pkg::CNT_W-1:0] c
  );
    return c <= iob_pkg::CNT_ONE;
  endfunction : cnt_expired

  function automatic logic [iob_pkg::CNT_W-1:0] cnt_dec(
    input logic [iob_pkg::CNT_W-1:0] c
  );
    return c - iob_pkg::CNT_ONE;
  endfunction : cnt_dec

  logic [iob_pkg::PHYS_W:0] poll_pick;

  assign poll_pick = pick_lowest(bus.data_lines[(1 << iob_pkg::PHYS_W)-1:0]);

  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    unique case (q.st)
      M_IDLE: begin
        // Interrupt service outranks a pending I/O instruction
        if (pi_req) begin
          d.busy      = 1'b1;
          d.poll      = 1'b1;
          d.rsp_pi    = 1'b1;
          d.sel       = {{iob_pkg::PHYS_W{1'b0}}, pi_chan};
          d.fn        = iob_pkg::FN_POLL;
          d.dout_oe_n = 1'b1;
          d.cnt       = iob_pkg::SETTLE_CYC;
          d.st        = M_SETUP;
        end else if (io_req) begin
          d.busy      = 1'b1;
          d.poll      = 1'b0;
          d.rsp_pi    = 1'b0;
          d.sel       = io_select;
          d.fn        = {1'b0, io_func};
          d.dout      = io_wdata;
          d.dout_oe_n = io_func[0];
          d.cnt       = iob_pkg::SETTLE_CYC;
          d.st        = M_SETUP;
        end
      end
      M_SETUP: begin
        // Select and function lines settle before the strobe
        if (cnt_expired(q.cnt)) begin
          d.strobe = 1'b1;
          d.cnt    = q.poll ? iob_pkg::POLL_CYC : iob_pkg::ACK_WAIT_CYC;
          d.st     = M_WAIT;
        end else begin
          d.cnt = cnt_dec(q.cnt);
        end
      end
      M_WAIT: begin
        if (q.poll) begin
          // Nobody acknowledges a poll; sample after a fixed wait
          if (cnt_expired(q.cnt)) begin
            d.rsp_data  = bus.data_lines;
            d.rsp_phys  = poll_pick[iob_pkg::PHYS_W-1:0];
            d.rsp_noack = !poll_pick[iob_pkg::PHYS_W];
            d.strobe    = 1'b0;
            d.cnt       = iob_pkg::HOLD_CYC;
            d.st        = M_HOLD;
          end else begin
            d.cnt = cnt_dec(q.cnt);
          end
        end else if (bus.transfer_ready) begin
          d.rsp_data  = bus.data_lines;
          d.rsp_noack = 1'b0;
          d.strobe    = 1'b0;
          d.cnt       = iob_pkg::HOLD_CYC;
          d.st        = M_HOLD;
        end else if (!bus.acknowledge) begin
          // Timeout only runs while no acknowledge is seen
          if (cnt_expired(q.cnt)) begin
            d.rsp_data  = iob_pkg::DATA_RST;
            d.rsp_noack = 1'b1;
            d.strobe    = 1'b0;
            d.cnt       = iob_pkg::HOLD_CYC;
            d.st        = M_HOLD;
          end else begin
            d.cnt = cnt_dec(q.cnt);
          end
        end
      end
      M_HOLD: begin
        // Lines stay put after the strobe drops so controllers can release
        if (cnt_expired(q.cnt)) begin
          d.dout_oe_n = 1'b1;
          if (q.poll && !q.rsp_noack) begin
            d.poll = 1'b0;
            d.sel  = {q.rsp_phys, q.sel[iob_pkg::CHAN_LSB +: iob_pkg::CHAN_W]};
            d.fn   = iob_pkg::FN_VEC;
            d.cnt  = iob_pkg::VEC_CYC;
            d.st   = M_SETUP;
          end else begin
            d.rsp_valid = 1'b1;
            d.busy      = 1'b0;
            d.st        = M_IDLE;
          end
        end else begin
          d.cnt = cnt_dec(q.cnt);
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '{st: M_IDLE, cnt: '0, sel: iob_pkg::SEL_RST, fn: 3'h0, strobe: 1'b0,
             dout: iob_pkg::DATA_RST, dout_oe_n: 1'b1, poll: 1'b0, busy: 1'b0,
             rsp_valid: 1'b0, rsp_pi: 1'b0, rsp_noack: 1'b0, rsp_phys: '0,
             rsp_data: iob_pkg::DATA_RST};
    end else begin
      q <= d;
    end
  end

  assign bus.select_lines   = q.sel;
  assign bus.function_code  = q.fn;
  assign bus.request_strobe = q.strobe;
  assign bus.m_data_o       = q.dout;
  assign bus.m_data_oe_n    = q.dout_oe_n;
  assign busy               = q.busy;
  assign rsp_valid          = q.rsp_valid;
  assign rsp_pi             = q.rsp_pi;
  assign rsp_noack          = q.rsp_noack;
  assign rsp_phys           = q.rsp_phys;
  assign rsp_data           = q.rsp_data;

endmodule : iob_master

// ===== test/iob_monitor.sv
`timescale 1ns/1ps
module iob_monitor (
  input wire logic                      clk_sys,
  input wire logic                      rst,
  input wire logic [iob_pkg::SEL_W-1:0] select_lines,
  input wire logic [2:0]                function_code,
  input wire logic                      request_strobe,
  input wire logic                      m_data_oe_n,
  input wire logic                      c_data_oe_n,
  input wire logic                      acknowledge,
  input wire logic                      transfer_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Poll strobe must stand ten cycles
  sequence s_poll_hold;
    request_strobe [*8] ##1 request_strobe [*2];
  endsequence
  sequence s_vec_start;
    $rose(request_strobe) && function_code == 3'b101;
  endsequence

  chk_transfer_ready_ends_strobe: assert property (request_strobe && transfer_ready |=> !request_strobe)
    else $error("strobe held after transfer");
  chk_strobe_clears: assert property ($fell(request_strobe) |-> ##2 (!acknowledge && !transfer_ready))
    else $error("handshake not cleared");
  chk_transfer_ready_with_ack: assert property (transfer_ready |-> acknowledge)
    else $error("transfer without acknowledge");
  chk_one_driver: assert property (m_data_oe_n || c_data_oe_n)
    else $error("data driven by both ends");
  chk_addr_stable: assert property (request_strobe |-> $stable(select_lines) && $stable(function_code))
    else $error("address moved under strobe");
  chk_io_settle: assert property ($rose(request_strobe) && !function_code[2] |->
    $past(select_lines, 5) == select_lines && $past(function_code, 5) == function_code)
    else $error("io strobe too early");
  chk_vec_settle: assert property (s_vec_start |->
    $past(function_code, 5) == 3'b101 && $past(select_lines, 5) == select_lines)
    else $error("vector strobe too early");
  chk_poll_quiet: assert property (request_strobe && function_code == 3'b100 |-> !acknowledge && !transfer_ready)
    else $error("handshake during poll");
  chk_poll_wait: assert property ($rose(request_strobe) && function_code == 3'b100 |-> s_poll_hold)
    else $error("poll strobe too short");
  // Slow ready is legal once acknowledged, so only unanswered strobes are bounded
  chk_noack_drop: assert property ((request_strobe && !acknowledge) [*3] |-> ##[0:60] !request_strobe)
    else $error("no timeout without acknowledge");
endmodule : iob_monitor

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] DEV  = 7'h05;
  localparam logic [3:0] PHYS = 4'ha;
  typedef struct {logic [1:0] fn; logic [6:0] sel; logic [35:0] wd; logic [35:0] rd; logic noack;} iob_row_s;
  logic        clk_sys, rst, io_req, pi_req, irq_req, ctl_ready, busy, rsp_valid, rsp_pi, rsp_noack;
  logic        wr_valid, vec_taken;
  logic [1:0]  io_func;
  logic [2:0]  pi_chan, irq_chan, wr_func, wr_f_seen;
  logic [3:0]  rsp_phys;
  logic [6:0]  io_select;
  logic [35:0] io_wdata, rsp_data, rd_data, vector_word, wr_data, wr_d_seen;
  int          n_errors, num_checks, cyc, wr_cnt, vec_cnt, w0;
  iob_row_s    rows [6];

  iob_bus_if bus_if ();
  iob_master u_iob_master (.clk_sys(clk_sys), .rst(rst), .bus(bus_if.master), .io_req(io_req),
    .io_func(io_func), .io_select(io_select), .io_wdata(io_wdata), .pi_req(pi_req), .pi_chan(pi_chan),
    .busy(busy), .rsp_valid(rsp_valid), .rsp_pi(rsp_pi), .rsp_noack(rsp_noack), .rsp_phys(rsp_phys),
    .rsp_data(rsp_data));
  iob_ctrl u_iob_ctrl (.clk_sys(clk_sys), .rst(rst), .bus(bus_if.ctrl), .dev_code(DEV), .phys_num(PHYS),
    .irq_req(irq_req), .irq_chan(irq_chan), .ctl_ready(ctl_ready), .rd_data(rd_data),
    .vector_word(vector_word), .wr_valid(wr_valid), .wr_func(wr_func), .wr_data(wr_data),
    .vec_taken(vec_taken));
  iob_monitor u_monitor (.clk_sys(clk_sys), .rst(rst), .select_lines(bus_if.select_lines),
    .function_code(bus_if.function_code), .request_strobe(bus_if.request_strobe),
    .m_data_oe_n(bus_if.m_data_oe_n), .c_data_oe_n(bus_if.c_data_oe_n),
    .acknowledge(bus_if.acknowledge), .transfer_ready(bus_if.transfer_ready));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Pulses are counted mid-cycle, clear of the edge that launches them
  always @(negedge clk_sys) begin
    cyc++;
    if (wr_valid === 1'b1) begin
      wr_cnt++;
      wr_f_seen = wr_func;
      wr_d_seen = wr_data;
    end
    if (vec_taken === 1'b1) vec_cnt++;
    // Whole plan needs well under two thousand cycles
    if (cyc == 6000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic kick(input logic pi);
    @(posedge clk_sys);
    #1;
    if (pi) pi_req = 1'b1;
    else io_req = 1'b1;
    @(posedge clk_sys);
    #1;
    pi_req = 1'b0;
    io_req = 1'b0;
  endtask : kick

  task automatic wait_rsp();
    for (int n = 0; n < 400; n++) begin
      @(posedge clk_sys);
      #1;
      if (rsp_valid === 1'b1) break;
    end
    check("rsp_valid", 36'(rsp_valid), 36'h1);
  endtask : wait_rsp

  task automatic wait_bus(input logic [2:0] f);
    for (int n = 0; n < 200; n++) begin
      @(posedge clk_sys);
      #1;
      if (bus_if.request_strobe === 1'b1 && bus_if.function_code === f) break;
    end
    check("strobe_seen", 36'(bus_if.request_strobe), 36'h1);
  endtask : wait_bus

  initial begin
    rst = 1'b1;
    {io_req, pi_req, irq_req} = 3'h0;
    ctl_ready = 1'b1;
    {io_func, io_select, io_wdata, pi_chan, irq_chan} = '0;
    rd_data = 36'h0;
    vector_word = 36'h1_2345_0abc;
    rows[0] = '{2'd0, DEV, 36'h0_0000_0001, 36'h0, 1'b0};
    rows[1] = '{2'd1, DEV, 36'h0, 36'h8_0000_0001, 1'b0};
    rows[2] = '{2'd2, DEV, 36'hf_ffff_ffff, 36'h0, 1'b0};
    rows[3] = '{2'd3, DEV, 36'h0, 36'h5_a5a5_a5a5, 1'b0};
    rows[4] = '{2'd2, 7'h45, 36'h1, 36'h0, 1'b1};
    rows[5] = '{2'd3, 7'h04, 36'h0, 36'h3, 1'b1};
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    check("busy", 36'(busy), 36'h0);
    check("strobe", 36'(bus_if.request_strobe), 36'h0);
    check("c_data_oe_n", 36'(bus_if.c_data_oe_n), 36'h1);
    check("c_ack_oe_n", 36'(bus_if.c_ack_oe_n), 36'h1);
    // Back to back: each row starts right after the previous answer
    foreach (rows[i]) begin
      io_func = rows[i].fn;
      io_select = rows[i].sel;
      io_wdata = rows[i].wd;
      rd_data = rows[i].rd;
      w0 = wr_cnt;
      kick(1'b0);
      wait_rsp();
      check("rsp_noack", 36'(rsp_noack), 36'(rows[i].noack));
      check("rsp_pi", 36'(rsp_pi), 36'h0);
      if (rows[i].noack) begin
        check("rsp_data", rsp_data, 36'h0);
        check("wr_count", 36'(wr_cnt), 36'(w0));
      end else if (rows[i].fn[0]) begin
        check("rsp_data", rsp_data, rows[i].rd);
      end else begin
        check("wr_count", 36'(wr_cnt), 36'(w0 + 1));
        check("wr_func", 36'(wr_f_seen), 36'({1'b0, rows[i].fn}));
        check("wr_data", wr_d_seen, rows[i].wd);
      end
    end
    // Slow controller: acknowledged but not yet ready
    ctl_ready = 1'b0;
    io_func = 2'd3;
    io_select = DEV;
    rd_data = 36'h0_dead_0001;
    kick(1'b0);
    repeat (30) @(posedge clk_sys);
    #1;
    check("acknowledge", 36'(bus_if.acknowledge), 36'h1);
    check("transfer_ready", 36'(bus_if.transfer_ready), 36'h0);
    check("busy", 36'(busy), 36'h1);
    ctl_ready = 1'b1;
    wait_rsp();
    check("rsp_data", rsp_data, 36'h0_dead_0001);
    // Interrupt on channel 3 from physical controller ten
    irq_req = 1'b1;
    irq_chan = 3'd3;
    pi_chan = 3'd3;
    kick(1'b1);
    wait_bus(3'b100);
    repeat (3) @(posedge clk_sys);
    #1;
    check("select_chan", 36'(bus_if.select_lines[2:0]), 36'h3);
    check("poll_bits", 36'(bus_if.data_lines[15:0]), 36'h0400);
    wait_bus(3'b101);
    check("select_vec", 36'(bus_if.select_lines), 36'({PHYS, 3'd3}));
    wait_rsp();
    check("rsp_pi", 36'(rsp_pi), 36'h1);
    check("rsp_noack", 36'(rsp_noack), 36'h0);
    check("rsp_phys", 36'(rsp_phys), 36'(PHYS));
    check("rsp_vector", rsp_data, vector_word);
    check("vec_count", 36'(vec_cnt), 36'h1);
    // Poll on a channel nobody interrupts on
    pi_chan = 3'd5;
    kick(1'b1);
    wait_rsp();
    check("rsp_pi", 36'(rsp_pi), 36'h1);
    check("rsp_noack", 36'(rsp_noack), 36'h1);
    check("vec_count", 36'(vec_cnt), 36'h1);
    // Reset in mid-transfer: both ends must let go at once, then recover
    ctl_ready = 1'b0;
    io_func = 2'd2;
    io_select = DEV;
    io_wdata = 36'h0_0000_00f0;
    kick(1'b0);
    repeat (10) @(posedge clk_sys);
    #1;
    check("ack_before_rst", 36'(bus_if.acknowledge), 36'h1);
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    check("busy_rst", 36'(busy), 36'h0);
    check("strobe_rst", 36'(bus_if.request_strobe), 36'h0);
    check("ack_rst", 36'(bus_if.acknowledge), 36'h0);
    check("m_data_oe_n_rst", 36'(bus_if.m_data_oe_n), 36'h1);
    check("c_data_oe_n_rst", 36'(bus_if.c_data_oe_n), 36'h1);
    ctl_ready = 1'b1;
    w0 = wr_cnt;
    kick(1'b0);
    wait_rsp();
    check("wr_count_rst", 36'(wr_cnt), 36'(w0 + 1));
    check("wr_data_rst", wr_d_seen, 36'h0_0000_00f0);
    summarize();
  end
endmodule : testbench
